// ===== rtl/dmaw_pack.sv
// Width converter: picks the read item from its byte lane, zero-extends
// or truncates it to the destination width and replicates it on all lanes.
// Purely combinational; the caller registers the result.
`include "dmaw_cfg.svh"
module dmaw_pack
	import dmaw_pkg::*;
(
	input wire logic [31:0] i_rdata,
	input wire logic [1:0] i_lane,
	input wire logic [1:0] i_src_width,
	input wire logic [1:0] i_dst_width,
	output logic [31:0] o_wdata
);
	logic [31:0] shifted;
	logic [31:0] item;

	always_comb
	begin
		shifted = i_rdata >> {i_lane, 3'b000};
		unique case (i_src_width)
			`DMAW_W8: item = {24'h000000, shifted[7:0]};
			`DMAW_W16: item = {16'h0000, shifted[15:0]};
			default: item = shifted;
		endcase
		// Narrow writes keep the low part and repeat it on every lane.
		unique case (i_dst_width)
			`DMAW_W8: o_wdata = {4{item[7:0]}};
			`DMAW_W16: o_wdata = {2{item[15:0]}};
			default: o_wdata = item;
		endcase
	end
endmodule : dmaw_pack

// ===== rtl/dmaw_top.sv
// Multi-channel DMA engine: width conversion, error handling, event flags.
// Assumes a word-only register port and a valid/ready master bus.
// Summary of operation
// - Each item converts between source and destination widths of 8, 16, 32.
// - A narrower source item lands in low bits, upper bits zero.
// - A 16-bit item to an 8-bit destination keeps its low byte.
// - A 32-bit item to a 16-bit destination keeps its low halfword.
// - Halfword to halfword is copied unchanged.
// - Destination address steps by its own width after each item.
// - Source steps by its width too, e.g. two while destination steps one.
// - The count is in items, one read and one write each.
// - Registers take word accesses only; narrower ones raise a fault.
// - Byte and halfword writes repeat the value on all lanes.
// - Access to the reserved region is a transfer error.
// - A transfer error clears the channel enable in hardware.
// - An error sets the error flag; interrupt only if enabled.
// - Each channel has half, complete and error events.
// - An event interrupts only when its flag and enable are set.
// - Each peripheral request line is muxed with the ADC request.
// - A per-channel select bit picks peripheral or ADC request.
// - A global flag per channel sets on any of its events.
// - Flags set by hardware; writing one to the clear register clears.
// - Equal priority goes to the lower channel index.
//
// Added by the designer: the register addresses and the plain strobed port.
`include "dmaw_cfg.svh"
module dmaw_top
	import dmaw_pkg::*;
#(
	parameter int NCH = 8
)
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic i_reg_word,
	output logic [31:0] o_reg_rdata,
	output logic o_hard_fault,
	input wire logic [NCH-1:0] i_periph_req,
	input wire logic i_adc_req,
	output logic [NCH-1:0] o_req_ack,
	output dmaw_mreq_type o_mbus,
	input wire logic i_mbus_ready,
	input wire logic i_mbus_error,
	input wire logic [31:0] i_mbus_rdata,
	output logic [NCH-1:0] o_irq
);
	localparam int CW = 3;

	if (NCH < 1 || NCH > 8)
	begin : g_bad_nch
		$error("dmaw_top: NCH must lie between 1 and 8");
	end

	dmaw_ccr_type ccr_ff [NCH];
	dmaw_ccr_type nxt_ccr [NCH];
	logic [31:0] par_ff [NCH];
	logic [31:0] nxt_par [NCH];
	logic [31:0] mar_ff [NCH];
	logic [31:0] nxt_mar [NCH];
	logic [31:0] cur_p_ff [NCH];
	logic [31:0] nxt_cur_p [NCH];
	logic [31:0] cur_m_ff [NCH];
	logic [31:0] nxt_cur_m [NCH];
	logic [15:0] ndt_ff [NCH];
	logic [15:0] nxt_ndt [NCH];
	logic [15:0] rem_ff [NCH];
	logic [15:0] nxt_rem [NCH];
	logic [NCH-1:0] reqsel_ff, nxt_reqsel, ack_ff, nxt_ack;
	dmaw_state_type state_ff, nxt_state;
	logic [CW-1:0] ch_ff, nxt_ch, win;
	dmaw_mreq_type mreq_ff, nxt_mreq;
	logic [31:0] rdata_ff, nxt_rdata;
	logic fault_ff, nxt_fault;
	logic [NCH-1:0] ev_done, ev_half, ev_err, req_line, pend;
	logic [4*NCH-1:0] flags_all;
	logic [31:0] conv_wdata, src_a, dst_a;
	logic [1:0] src_w, dst_w;
	logic [3:0] rch_n;
	logic [CW-1:0] rch;
	logic rch_ok, reg_wr, reg_rd, any, xfer_err;
	dmaw_ccr_type cc;

	function automatic logic [31:0] step_of(input logic [1:0] w);
		step_of = (w == `DMAW_W8) ? 32'h00000001 :
			(w == `DMAW_W16) ? 32'h00000002 : 32'h00000004;
	endfunction : step_of

	assign reg_wr = i_reg_wr & i_reg_word;
	assign reg_rd = i_reg_rd & i_reg_word;
	assign rch_n = i_reg_addr[7:4] - `DMAW_CH_BASE;
	assign rch = rch_n[CW-1:0];
	assign rch_ok = (i_reg_addr[7:4] >= `DMAW_CH_BASE) && (rch_n < NCH);

	// The direction bit decides which port is read and which is written.
	assign cc = ccr_ff[ch_ff];
	assign src_w = cc.dir ? cc.mem_item_width : cc.src_item_width;
	assign dst_w = cc.dir ? cc.src_item_width : cc.mem_item_width;
	assign src_a = cc.dir ? cur_m_ff[ch_ff] : cur_p_ff[ch_ff];
	assign dst_a = cc.dir ? cur_p_ff[ch_ff] : cur_m_ff[ch_ff];

	dmaw_pack u_pack
	(
		.i_rdata(i_mbus_rdata),
		.i_lane(src_a[1:0]),
		.i_src_width(src_w),
		.i_dst_width(dst_w),
		.o_wdata(conv_wdata)
	);

	always_comb
	begin
		nxt_ccr = ccr_ff;
		nxt_par = par_ff;
		nxt_mar = mar_ff;
		nxt_cur_p = cur_p_ff;
		nxt_cur_m = cur_m_ff;
		nxt_ndt = ndt_ff;
		nxt_rem = rem_ff;
		nxt_reqsel = reqsel_ff;
		nxt_state = state_ff;
		nxt_ch = ch_ff;
		nxt_mreq = mreq_ff;
		nxt_ack = '0;
		nxt_rdata = `DMAW_WORD_RST;
		nxt_fault = (i_reg_wr | i_reg_rd) & ~i_reg_word;
		ev_done = '0;
		ev_half = '0;
		ev_err = '0;
		xfer_err = 1'b0;
		win = '0;
		any = 1'b0;
		// Later hits win: higher priority, then lower index.
		for (int p = 0; p < 4; p++)
			for (int c = NCH - 1; c >= 0; c--)
				if (pend[c] && ccr_ff[c].prio == 2'(p))
				begin
					win = CW'(c);
					any = 1'b1;
				end
		if (reg_wr && i_reg_addr == `DMAW_OFS_REQSEL)
			nxt_reqsel = i_reg_wdata[NCH-1:0];
		if (reg_wr && rch_ok)
		begin
			unique case (i_reg_addr[3:2])
				`DMAW_SUB_CCR:
				begin
					nxt_ccr[rch] = dmaw_ccr_type'(i_reg_wdata);
					nxt_ccr[rch].rsvd = '0;
					nxt_ccr[rch].rsvd_lo = 1'b0;
					if (!ccr_ff[rch].en && i_reg_wdata[0])
					begin
						nxt_cur_p[rch] = par_ff[rch];
						nxt_cur_m[rch] = mar_ff[rch];
					end
				end
				`DMAW_SUB_PAR: nxt_par[rch] = i_reg_wdata;
				`DMAW_SUB_MAR: nxt_mar[rch] = i_reg_wdata;
				`DMAW_SUB_NDT:
				begin
					nxt_ndt[rch] = i_reg_wdata[15:0];
					nxt_rem[rch] = i_reg_wdata[15:0];
				end
			endcase
		end
		if (reg_rd)
		begin
			if (i_reg_addr == `DMAW_OFS_ISR)
				nxt_rdata = 32'(flags_all);
			else if (i_reg_addr == `DMAW_OFS_REQSEL)
				nxt_rdata = 32'(reqsel_ff);
			else if (rch_ok)
			begin
				unique case (i_reg_addr[3:2])
					`DMAW_SUB_CCR: nxt_rdata = ccr_ff[rch];
					`DMAW_SUB_PAR: nxt_rdata = par_ff[rch];
					`DMAW_SUB_MAR: nxt_rdata = mar_ff[rch];
					`DMAW_SUB_NDT: nxt_rdata = {16'h0000, rem_ff[rch]};
				endcase
			end
		end
		unique case (state_ff)
			DMAW_IDLE:
			begin
				if (any)
				begin
					nxt_ch = win;
					nxt_state = DMAW_RD;
				end
			end
			DMAW_RD:
			begin
				if (!mreq_ff.valid)
				begin
					if (src_a[31:28] == `DMAW_RSV_NIB)
						xfer_err = 1'b1;
					else
						nxt_mreq = '{1'b1, 1'b0, src_w, src_a, 32'h00000000};
				end
				else if (i_mbus_ready)
				begin
					if (i_mbus_error || dst_a[31:28] == `DMAW_RSV_NIB)
						xfer_err = 1'b1;
					else
					begin
						nxt_mreq = '{1'b1, 1'b1, dst_w, dst_a, conv_wdata};
						nxt_state = DMAW_WR;
					end
				end
			end
			DMAW_WR:
			begin
				if (i_mbus_ready && i_mbus_error)
					xfer_err = 1'b1;
				else if (i_mbus_ready)
				begin
					nxt_mreq = '0;
					nxt_state = DMAW_IDLE;
					nxt_rem[ch_ff] = rem_ff[ch_ff] - 16'h0001;
					nxt_ack[ch_ff] = ~cc.m2m;
					if (cc.periph_addr_step_en)
						nxt_cur_p[ch_ff] = cur_p_ff[ch_ff] +
							step_of(cc.src_item_width);
					if (cc.mem_addr_step_en)
						nxt_cur_m[ch_ff] = cur_m_ff[ch_ff] +
							step_of(cc.mem_item_width);
					ev_done[ch_ff] = (nxt_rem[ch_ff] == 16'h0000);
					ev_half[ch_ff] = (ndt_ff[ch_ff][15:1] != 15'h0000) &&
						(nxt_rem[ch_ff] == {1'b0, ndt_ff[ch_ff][15:1]});
				end
			end
		endcase
		if (xfer_err)
		begin
			nxt_mreq = '0;
			nxt_state = DMAW_IDLE;
			nxt_ccr[ch_ff].en = 1'b0;
			ev_err[ch_ff] = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			for (int c = 0; c < NCH; c++)
			begin
				ccr_ff[c] <= `DMAW_CCR_RST;
				par_ff[c] <= `DMAW_WORD_RST;
				mar_ff[c] <= `DMAW_WORD_RST;
				cur_p_ff[c] <= `DMAW_WORD_RST;
				cur_m_ff[c] <= `DMAW_WORD_RST;
				ndt_ff[c] <= `DMAW_CNT_RST;
				rem_ff[c] <= `DMAW_CNT_RST;
			end
			reqsel_ff <= '0;
			ack_ff <= '0;
			state_ff <= DMAW_IDLE;
			ch_ff <= '0;
			mreq_ff <= '0;
			rdata_ff <= `DMAW_WORD_RST;
			fault_ff <= 1'b0;
		end
		else
		begin
			ccr_ff <= nxt_ccr;
			par_ff <= nxt_par;
			mar_ff <= nxt_mar;
			cur_p_ff <= nxt_cur_p;
			cur_m_ff <= nxt_cur_m;
			ndt_ff <= nxt_ndt;
			rem_ff <= nxt_rem;
			reqsel_ff <= nxt_reqsel;
			ack_ff <= nxt_ack;
			state_ff <= nxt_state;
			ch_ff <= nxt_ch;
			mreq_ff <= nxt_mreq;
			rdata_ff <= nxt_rdata;
			fault_ff <= nxt_fault;
		end
	end

	assign o_reg_rdata = rdata_ff;
	assign o_hard_fault = fault_ff;
	assign o_req_ack = ack_ff;
	assign o_mbus = mreq_ff;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);

	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		logic [3:0] flg_ff, nxt_flg, clr, set;
		logic irq_ff, nxt_irq;

		// A channel is not offered again while its acknowledge is out.
		assign req_line[c] = reqsel_ff[c] ? i_adc_req : i_periph_req[c];
		assign pend[c] = ccr_ff[c].en && rem_ff[c] != 16'h0000 &&
			(ccr_ff[c].m2m || (req_line[c] && !ack_ff[c]));

		always_comb
		begin
			clr = (reg_wr && i_reg_addr == `DMAW_OFS_FLAG_CLEAR_REG) ?
				i_reg_wdata[4*c +: 4] : 4'h0;
			set = {ev_err[c], ev_half[c], ev_done[c],
				ev_err[c] | ev_half[c] | ev_done[c]};
			nxt_flg = (flg_ff & ~clr) | set;
			nxt_irq = |(nxt_flg[3:1] & {ccr_ff[c].xfer_error_irq_en,
				ccr_ff[c].half_done_irq_en, ccr_ff[c].all_done_irq_en});
		end

		always_ff @(posedge i_core_clk or posedge i_reset)
		begin
			if (i_reset)
			begin
				flg_ff <= 4'h0;
				irq_ff <= 1'b0;
			end
			else
			begin
				flg_ff <= nxt_flg;
				irq_ff <= nxt_irq;
			end
		end

		assign flags_all[4*c +: 4] = flg_ff;
		assign o_irq[c] = irq_ff;

		chk_err_flags: assert property (ev_err[c] |=> flg_ff[`DMAW_F_ERR] && flg_ff[`DMAW_F_ANY]) else $error("error event lost");
		chk_err_irq: assert property (ev_err[c] && ccr_ff[c].xfer_error_irq_en |=> irq_ff) else $error("error irq missing");
		chk_set_wins: assert property (ev_done[c] && clr[`DMAW_F_DONE] |=> flg_ff[`DMAW_F_DONE]) else $error("set lost to clear");
		chk_irq_gate: assert property (irq_ff |-> |(flg_ff[3:1] & $past({ccr_ff[c].xfer_error_irq_en, ccr_ff[c].half_done_irq_en, ccr_ff[c].all_done_irq_en}))) else $error("irq without enabled flag");
	end

	sequence s_wr_done;
		state_ff == DMAW_WR && i_mbus_ready && !i_mbus_error;
	endsequence

	chk_count_item: assert property (s_wr_done |=> rem_ff[$past(ch_ff)] == $past(rem_ff[ch_ff]) - 16'h0001) else $error("count not one per item");
	chk_mem_step: assert property ((s_wr_done and cc.mem_addr_step_en) |=> cur_m_ff[$past(ch_ff)] == $past(cur_m_ff[ch_ff]) + $past(step_of(cc.mem_item_width))) else $error("bad memory step");
	chk_err_disable: assert property (state_ff == DMAW_WR && i_mbus_ready && i_mbus_error |=> !ccr_ff[ch_ff].en && state_ff == DMAW_IDLE) else $error("error did not disable");
	chk_rsv_guard: assert property (mreq_ff.valid |-> mreq_ff.addr[31:28] != `DMAW_RSV_NIB) else $error("reserved access issued");
	chk_lane_byte: assert property (mreq_ff.valid && mreq_ff.write && mreq_ff.size == `DMAW_W8 |-> mreq_ff.wdata == {4{mreq_ff.wdata[7:0]}}) else $error("byte not replicated");
	chk_lane_half: assert property (mreq_ff.valid && mreq_ff.write && mreq_ff.size == `DMAW_W16 |-> mreq_ff.wdata == {2{mreq_ff.wdata[15:0]}}) else $error("halfword not replicated");
	chk_zero_ext: assert property (state_ff == DMAW_RD && mreq_ff.valid && i_mbus_ready && src_w == `DMAW_W8 && dst_w == `DMAW_W32 |=> !mreq_ff.valid || mreq_ff.wdata[31:8] == 24'h000000) else $error("upper bits not zero");
	chk_word_only: assert property ((i_reg_wr || i_reg_rd) && !i_reg_word |=> o_hard_fault && $stable(reqsel_ff)) else $error("narrow access not refused");
endmodule : dmaw_top

// ===== shared/dmaw_cfg.svh
// Register map, field positions, reset values and encodings of the DMA.
// Holds definitions only; included by the design files by bare name.
`ifndef DMAW_CFG_SVH
`define DMAW_CFG_SVH
`define DMAW_OFS_ISR 8'h00
`define DMAW_OFS_FLAG_CLEAR_REG 8'h04
`define DMAW_OFS_REQSEL 8'h08
`define DMAW_CH_BASE 4'h1
`define DMAW_SUB_CCR 2'h0
`define DMAW_SUB_PAR 2'h1
`define DMAW_SUB_MAR 2'h2
`define DMAW_SUB_NDT 2'h3
`define DMAW_F_ANY 0
`define DMAW_F_DONE 1
`define DMAW_F_HALF 2
`define DMAW_F_ERR 3
`define DMAW_W8 2'h0
`define DMAW_W16 2'h1
`define DMAW_W32 2'h2
`define DMAW_CCR_RST 32'h00000000
`define DMAW_WORD_RST 32'h00000000
`define DMAW_CNT_RST 16'h0000
`define DMAW_RSV_NIB 4'hF
`endif

// ===== shared/dmaw_pkg.sv
// Types shared by the DMA width engine and its lane packer.
// Assumes nothing of its surroundings.
package dmaw_pkg;
	typedef enum logic [2:0]
	{
		DMAW_IDLE = 3'b001,
		DMAW_RD = 3'b010,
		DMAW_WR = 3'b100
	} dmaw_state_type;

	typedef struct packed
	{
		logic [16:0] rsvd;
		logic m2m;
		logic [1:0] prio;
		logic [1:0] mem_item_width;
		logic [1:0] src_item_width;
		logic rsvd_lo;
		logic mem_addr_step_en;
		logic periph_addr_step_en;
		logic dir;
		logic xfer_error_irq_en;
		logic half_done_irq_en;
		logic all_done_irq_en;
		logic en;
	} dmaw_ccr_type;

	typedef struct packed
	{
		logic valid;
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dmaw_mreq_type;
endpackage : dmaw_pkg

// ===== testbench/dmaw_slave_model.sv
// Memory slave on the master request port, 64 words deep.
// Assumes the request stands until ready; region 0xE can be made to fail.
module dmaw_slave_model
	import dmaw_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire dmaw_mreq_type i_mbus,
	input wire logic [1:0] i_wait,
	input wire logic i_err_en,
	output logic o_ready,
	output logic o_error,
	output logic [31:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [64];
	logic [1:0] cnt_ff;
	logic [5:0] idx;
	logic [3:0] be;
	assign idx = i_mbus.addr[7:2];
	assign o_ready = i_mbus.valid && (cnt_ff == i_wait);
	assign o_error = o_ready && i_err_en && (i_mbus.addr[31:28] == 4'hE);
	// Outside its answer cycle the read bus shows the inverse of the word.
	assign o_rdata = o_ready ? mem[idx] : ~mem[idx];
	assign be = (i_mbus.size == 2'h2) ? 4'hF : (i_mbus.size == 2'h1) ?
		(i_mbus.addr[1] ? 4'hC : 4'h3) : (4'h1 << i_mbus.addr[1:0]);
	initial
	begin
		for (int i = 0; i < 64; i++)
			mem[i] = {8'(4 * i + 3), 8'(4 * i + 2), 8'(4 * i + 1), 8'(4 * i)};
	end
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset || !i_mbus.valid || o_ready)
			cnt_ff <= 2'h0;
		else
			cnt_ff <= cnt_ff + 2'h1;
	end
	always @(posedge i_core_clk)
	begin
		for (int b = 0; b < 4; b++)
			if (o_ready && i_mbus.write && !o_error && be[b])
				mem[idx][8 * b +: 8] <= i_mbus.wdata[8 * b +: 8];
	end
endmodule : dmaw_slave_model

// ===== testbench/testbench.sv
// Self-checking bench: register port master, requesters and a bus slave.
// Assumes the design package is compiled before this file.
module testbench
	import dmaw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic reg_word = 1'b1, adc_req = 1'b0, err_en = 1'b0, ready, merr;
	logic hard_fault;
	logic [7:0] reg_addr = 8'h00, periph_req = 8'h00, req_ack, irq;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rdata;
	logic [31:0] ra[$], wa[$], wd[$];
	logic [1:0] ws[$], wait_sel = 2'h0;
	dmaw_mreq_type mbus;
	int error_cnt = 0, checked = 0;
	int ack_cnt[8] = '{default: 0};
	always #12.5 clk = ~clk;
	dmaw_top #(.NCH(8)) dmaw_top_i (.i_core_clk(clk), .i_reset(reset),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
		.i_reg_rd(reg_rd), .i_reg_word(reg_word), .o_reg_rdata(reg_rdata),
		.o_hard_fault(hard_fault), .i_periph_req(periph_req),
		.i_adc_req(adc_req), .o_req_ack(req_ack), .o_mbus(mbus),
		.i_mbus_ready(ready), .i_mbus_error(merr), .i_mbus_rdata(rdata),
		.o_irq(irq));
	dmaw_slave_model dmaw_slave_model_i (.i_core_clk(clk), .i_reset(reset),
		.i_mbus(mbus), .i_wait(wait_sel), .i_err_en(err_en), .o_ready(ready),
		.o_error(merr), .o_rdata(rdata));
	always @(posedge clk)
	begin
		if (mbus.valid && ready && !mbus.write)
			ra.push_back(mbus.addr);
		if (mbus.valid && ready && mbus.write)
		begin
			wa.push_back(mbus.addr);
			wd.push_back(mbus.wdata);
			ws.push_back(mbus.size);
		end
		for (int c = 0; c < 8; c++)
			if (req_ack[c] === 1'b1)
				ack_cnt[c]++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask : rdc
	// Polls the status register until all bits of the mask are set.
	task automatic wait_isr(input logic [31:0] m);
		for (int n = 0; n < 60; n++)
		begin
			@(posedge clk);
			reg_addr <= 8'h00;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1;
			if ((reg_rdata & m) === m)
				return;
		end
		check(reg_rdata & m, m);
	endtask : wait_isr
	task automatic cfg(input int c, input logic [31:0] ccr, par, mar, item_count);
		logic [7:0] b;
		b = 8'(16 + 16 * c);
		wr(b, 32'h0);
		wr(b + 8'h04, par);
		wr(b + 8'h08, mar);
		wr(b + 8'h0C, item_count);
		wr(b, ccr);
	endtask : cfg
	// Holds a request until its acknowledge shows, then drops it.
	task automatic serve(input int c, input bit adc);
		int n;
		n = ack_cnt[c];
		@(posedge clk);
		if (adc)
			adc_req <= 1'b1;
		else
			periph_req[c] <= 1'b1;
		for (int t = 0; t < 60 && req_ack[c] !== 1'b1; t++)
			@(posedge clk) #1;
		if (adc)
			adc_req <= 1'b0;
		else
			periph_req[c] <= 1'b0;
		check(req_ack[c], 1'b1);
	endtask : serve
	function automatic logic [31:0] exp_item(input int sw, dw, k);
		logic [7:0] a;
		logic [31:0] v;
		a = 8'(k << sw);
		v = {a + 8'h03, a + 8'h02, a + 8'h01, a};
		if (sw == 0)
			v = {24'h0, v[7:0]};
		if (sw == 1)
			v = {16'h0, v[15:0]};
		if (dw == 0)
			v = {4{v[7:0]}};
		if (dw == 1)
			v = {2{v[15:0]}};
		return v;
	endfunction : exp_item
	task automatic t_regs;
		rdc(8'h00, 32'h0);
		rdc(8'h10, 32'h0);
		rdc(8'hF0, 32'h0);
		wr(8'h00, 32'hFFFFFFFF);
		rdc(8'h00, 32'h0);
		reg_word <= 1'b0;
		wr(8'h08, 32'h4);
		#1 check(hard_fault, 1'b1);
		reg_word <= 1'b1;
		rdc(8'h08, 32'h0);
		// One byte item; the clear of the done flag meets its own event.
		cfg(0, 32'h4041, 32'h0, 32'h80, 32'h1);
		repeat (2) @(posedge clk);
		wr(8'h04, 32'h2);
		rdc(8'h00, 32'h3);
		wr(8'h04, 32'h3);
		$display("test registers done");
	endtask : t_regs
	task automatic t_widths;
		int i;
		i = 0;
		for (int sw = 0; sw < 3; sw++)
			for (int dw = 0; dw < 3; dw++)
			begin
				ra.delete();
				wa.delete();
				wd.delete();
				ws.delete();
				wait_sel <= 2'(i % 3);
				cfg(0, 32'h4061 | (sw << 8) | (dw << 10) | ((i % 2) << 1),
					32'h0, 32'h80, 32'h4);
				wait_isr(32'h7);
				repeat (10) @(posedge clk);
				check(wa.size(), 4);
				for (int k = 0; k < 4; k++)
				begin
					check(ra[k], k << sw);
					check(wa[k], 32'h80 + (k << dw));
					check(ws[k], dw);
					check(wd[k], exp_item(sw, dw, k));
				end
				check(irq[0], i % 2);
				wr(8'h04, 32'hF);
				rdc(8'h00, 32'h0);
				check(irq[0], 1'b0);
				i++;
			end
		$display("test widths done");
	endtask : t_widths
	task automatic t_error;
		int n;
		n = ra.size();
		cfg(1, 32'h4061, 32'hF0000000, 32'h80, 32'h2);
		wait_isr(32'h90);
		check(ra.size(), n);
		rdc(8'h20, 32'h4060);
		check(irq[1], 1'b0);
		wr(8'h04, 32'hF0);
		err_en <= 1'b1;
		n = ack_cnt[1];
		cfg(1, 32'h69, 32'h0, 32'hE0000080, 32'h2);
		periph_req[1] <= 1'b1;
		wait_isr(32'h90);
		check(irq[1], 1'b1);
		rdc(8'h20, 32'h68);
		n = ra.size();
		repeat (30) @(posedge clk);
		check(ra.size(), n);
		periph_req[1] <= 1'b0;
		err_en <= 1'b0;
		wr(8'h04, 32'hF0);
		rdc(8'h00, 32'h0);
		$display("test errors done");
	endtask : t_error
	task automatic t_mux;
		int n;
		cfg(2, 32'hA01, 32'h0, 32'h80, 32'h4);
		adc_req <= 1'b1;
		repeat (20) @(posedge clk);
		check(ack_cnt[2], 0);
		adc_req <= 1'b0;
		serve(2, 1'b0);
		wr(8'h08, 32'h4);
		periph_req[2] <= 1'b1;
		repeat (20) @(posedge clk);
		check(ack_cnt[2], 1);
		periph_req[2] <= 1'b0;
		serve(2, 1'b1);
		cfg(3, 32'hA01, 32'h40, 32'h90, 32'h1);
		cfg(4, 32'hA01, 32'h44, 32'h94, 32'h1);
		n = ra.size();
		fork
			serve(3, 1'b0);
			serve(4, 1'b0);
		join
		check(ra[n], 32'h40);
		$display("test request select done");
	endtask : t_mux
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_regs;
		t_widths;
		t_error;
		t_mux;
		end_of_test;
	end
	initial
	begin
		#1000000;
		error_cnt++;
		end_of_test;
	end
endmodule : testbench
